// ---- qrwb_pkg.sv ----
// Constants and types shared by the quad word read and wrap burst block
`default_nettype none
package qrwb_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int DMY_W = 4;

  // Command codes
  localparam logic [7:0] OP_WORD_QUAD_READ = 8'hE7;
  localparam logic [7:0] OP_OCTAL_WORD_READ = 8'hE3;
  localparam logic [7:0] OP_QUAD_FAST_READ = 8'hEB;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_BURST_WRAP_PM = 8'h0C;

  // Last index of each phase, counted in clocks
  localparam logic [CNT_W-1:0] CMD_LAST_SPI = 5'h07;
  localparam logic [CNT_W-1:0] CMD_LAST_PM = 5'h01;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h05;
  localparam logic [CNT_W-1:0] MODE_LAST = 5'h01;
  localparam logic [CNT_W-1:0] WCFG_LAST = 5'h1F;

  // Dummy clocks after the mode bits, and base of the peripheral mode dummy count after the address
  localparam logic [DMY_W-1:0] DMY_WORD = 4'h2;
  localparam logic [DMY_W-1:0] DMY_OCTAL = 4'h0;
  localparam logic [DMY_W-1:0] DMY_FAST = 4'h4;
  localparam logic [DMY_W-1:0] DMY_PM_BASE = 4'h2;

  // Mode bit code that keeps the opcode skipped
  localparam logic [1:0] SKIP_CODE = 2'h2;

  // Wrap setting positions and values after reset
  localparam int WCFG_DIS_POS = 4;
  localparam int WCFG_LEN_LO = 5;
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  localparam logic [5:0] WRAP_MASK_MAX = 6'h3F;
  localparam logic [1:0] WRAP_LEN_MAX = 2'h3;

  // Synchroniser reset: chip select idle high, clock low
  localparam logic [5:0] SYNC_RST = 6'h20;
  localparam int SYNC_CS_POS = 5;
  localparam int SYNC_CK_POS = 4;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CMD = 8'h02,
    S_ADDR = 8'h04,
    S_MODE = 8'h08,
    S_DUMMY = 8'h10,
    S_DATA = 8'h20,
    S_WCFG = 8'h40,
    S_SKIP = 8'h80
  } qrwb_state_t;

endpackage : qrwb_pkg
`default_nettype wire

// ---- qrwb_smp_if.sv ----
// Sampled pin events passed from the synchroniser to the sequencer
`timescale 1ns/10ps
`default_nettype none
interface qrwb_smp_if;
  logic rise;
  logic fall;
  logic cs_act;
  logic cs_start;
  logic [3:0] io;
  modport src (output rise, output fall, output cs_act, output cs_start,
               output io);
  modport dst (input rise, input fall, input cs_act, input cs_start,
               input io);
endinterface : qrwb_smp_if
`default_nettype wire

// ---- qrwb_sync.sv ----
// Pin synchroniser and serial clock edge finder
`timescale 1ns/10ps
`default_nettype none
module qrwb_sync
  import qrwb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_in,
  qrwb_smp_if.src smp
);
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= {cs_n_pin, sclk_pin, io_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign smp.rise = s2_q[SYNC_CK_POS] & ~s3_q[SYNC_CK_POS];
  assign smp.fall = ~s2_q[SYNC_CK_POS] & s3_q[SYNC_CK_POS];
  assign smp.cs_act = ~s2_q[SYNC_CS_POS];
  assign smp.cs_start = ~s2_q[SYNC_CS_POS] & s3_q[SYNC_CS_POS];
  assign smp.io = s2_q[3:0];
endmodule : qrwb_sync
`default_nettype wire

// ---- qrwb_top.sv ----
// Quad word read, octal word read and wrap burst command sequencer
`timescale 1ns/10ps
`default_nettype none
module qrwb_top
  import qrwb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_io_enable_bit,
  input wire logic quad_peripheral_mode,
  input wire logic [1:0] periph_dummy_code,
  input wire logic [1:0] periph_wrap_code,
  input wire logic soft_reset,
  output logic [qrwb_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [qrwb_pkg::DATA_W-1:0] mem_rdata,
  output logic wrap_disable_bit,
  output logic [1:0] wrap_length_field,
  output logic execute_in_place,
  output logic busy
);
  import qrwb_pkg::*;

  qrwb_smp_if smp ();

  qrwb_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .io_in(io_in),
    .smp(smp)
  );

  qrwb_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DMY_W-1:0] dmy_q;
  logic cont_q;
  logic [7:0] cont_op_q;
  logic [1:0] skip_q;
  logic wrap_dis_q;
  logic [1:0] wrap_len_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic lo_q;
  logic started_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;

  logic rx;
  logic [7:0] cmd_byte;
  logic cmd_last;
  logic [DMY_W-1:0] pm_dmy;
  logic [DMY_W-1:0] mode_dmy;
  logic wrap_en;
  logic [1:0] wrap_len;
  logic [ADDR_W-1:0] addr_eff;
  logic [7:0] wcfg_byte;

  // Next state after a complete opcode
  function automatic qrwb_state_t decode_cmd(
    input logic [7:0] code,
    input logic pmode,
    input logic qen
  );
    qrwb_state_t nxt;
    nxt = S_SKIP;
    if (!pmode && qen && (code == OP_WORD_QUAD_READ)) begin
      nxt = S_ADDR;
    end else if (!pmode && qen && (code == OP_OCTAL_WORD_READ)) begin
      nxt = S_ADDR;
    end else if (!pmode && qen && (code == OP_QUAD_FAST_READ)) begin
      nxt = S_ADDR;
    end else if (!pmode && (code == OP_SET_WRAP)) begin
      nxt = S_WCFG;
    end else if (pmode && (code == OP_BURST_WRAP_PM)) begin
      nxt = S_ADDR;
    end
    return nxt;
  endfunction : decode_cmd

  // Next byte address, confined to an aligned section when wrapping
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a,
    input logic en,
    input logic [1:0] len
  );
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = {18'h0, WRAP_MASK_MAX >> (WRAP_LEN_MAX - len)};
    inc = a + 24'h1;
    if (en) begin
      return (a & ~mask) | (inc & mask);
    end
    return inc;
  endfunction : next_addr

  assign rx = smp.rise && smp.cs_act && !smp.cs_start;

  // Opcode assembly, serial or four bits per clock
  assign cmd_byte = quad_peripheral_mode ? {sr_q[3:0], smp.io}
                                         : {sr_q[6:0], smp.io[0]};
  assign cmd_last = quad_peripheral_mode ? (cnt_q == CMD_LAST_PM)
                                         : (cnt_q == CMD_LAST_SPI);

  // Peripheral mode dummy count 2, 4, 6 or 8
  assign pm_dmy = {1'b0, periph_dummy_code, 1'b0} + DMY_PM_BASE;

  always_comb begin
    mode_dmy = DMY_FAST;
    if (op_q == OP_WORD_QUAD_READ) begin
      mode_dmy = DMY_WORD;
    end else if (op_q == OP_OCTAL_WORD_READ) begin
      mode_dmy = DMY_OCTAL;
    end
  end

  // Wrap source per opcode
  always_comb begin
    if (op_q == OP_BURST_WRAP_PM) begin
      wrap_en = 1'b1;
      wrap_len = periph_wrap_code;
    end else begin
      wrap_en = !wrap_dis_q;
      wrap_len = wrap_len_q;
    end
  end

  // Start address with forced alignment of word reads
  always_comb begin
    addr_eff = addr_q;
    if (op_q == OP_WORD_QUAD_READ) begin
      addr_eff[0] = 1'b0;
    end else if (op_q == OP_OCTAL_WORD_READ) begin
      addr_eff[3:0] = 4'h0;
    end
  end

  assign wcfg_byte = {sr_q[6:0], smp.io[0]};

  // Command phases
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      sr_q <= '0;
      op_q <= '0;
      addr_q <= '0;
      dmy_q <= '0;
    end else if (!smp.cs_act) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else if (smp.cs_start) begin
      cnt_q <= '0;
      if (cont_q) begin
        state_q <= S_ADDR;
        op_q <= cont_op_q;
      end else begin
        state_q <= S_CMD;
      end
    end else if (rx) begin
      case (state_q)
        S_CMD: begin
          sr_q <= cmd_byte;
          cnt_q <= cnt_q + 5'h1;
          if (cmd_last) begin
            op_q <= cmd_byte;
            cnt_q <= '0;
            state_q <= decode_cmd(cmd_byte, quad_peripheral_mode,
                                  quad_io_enable_bit);
          end
        end
        S_ADDR: begin
          addr_q <= {addr_q[ADDR_W-5:0], smp.io};
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == ADDR_LAST) begin
            cnt_q <= '0;
            if (op_q == OP_BURST_WRAP_PM) begin
              dmy_q <= pm_dmy;
              state_q <= S_DUMMY;
            end else begin
              state_q <= S_MODE;
            end
          end
        end
        S_MODE: begin
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == MODE_LAST) begin
            cnt_q <= '0;
            dmy_q <= mode_dmy;
            if (mode_dmy == DMY_OCTAL) begin
              state_q <= S_DATA;
            end else begin
              state_q <= S_DUMMY;
            end
          end
        end
        S_DUMMY: begin
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == {1'b0, dmy_q - 4'h1}) begin
            cnt_q <= '0;
            state_q <= S_DATA;
          end
        end
        S_WCFG: begin
          sr_q <= wcfg_byte;
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == WCFG_LAST) begin
            state_q <= S_SKIP;
          end
        end
        S_DATA, S_SKIP, S_IDLE: begin
          state_q <= state_q;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Continuous read mode tracking
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cont_q <= 1'b0;
      cont_op_q <= '0;
      skip_q <= '0;
    end else if (soft_reset) begin
      cont_q <= 1'b0;
    end else if (rx && (state_q == S_MODE)) begin
      if (cnt_q == '0) begin
        skip_q <= smp.io[1:0];
      end else begin
        cont_q <= (skip_q == SKIP_CODE);
        cont_op_q <= op_q;
      end
    end
  end

  // Wrap setting register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrap_dis_q <= WRAP_DIS_RST;
      wrap_len_q <= WRAP_LEN_RST;
    end else if (soft_reset) begin
      wrap_dis_q <= WRAP_DIS_RST;
      wrap_len_q <= WRAP_LEN_RST;
    end else if (rx && (state_q == S_WCFG) && (cnt_q == WCFG_LAST)) begin
      wrap_dis_q <= wcfg_byte[WCFG_DIS_POS];
      wrap_len_q <= wcfg_byte[WCFG_LEN_LO+1:WCFG_LEN_LO];
    end
  end

  // Data output on falling clock edges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_addr_q <= '0;
      lo_q <= 1'b0;
      started_q <= 1'b0;
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (!smp.cs_act) begin
      lo_q <= 1'b0;
      started_q <= 1'b0;
      io_oe_q <= '0;
    end else if (state_q != S_DATA) begin
      rd_addr_q <= addr_eff;
      lo_q <= 1'b0;
      started_q <= 1'b0;
    end else if (smp.fall) begin
      started_q <= 1'b1;
      io_oe_q <= 4'hF;
      if (!lo_q) begin
        io_out_q <= mem_rdata[7:4];
        lo_q <= 1'b1;
      end else begin
        io_out_q <= mem_rdata[3:0];
        lo_q <= 1'b0;
        rd_addr_q <= next_addr(rd_addr_q, wrap_en, wrap_len);
      end
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign mem_addr = rd_addr_q;
  assign wrap_disable_bit = wrap_dis_q;
  assign wrap_length_field = wrap_len_q;
  assign execute_in_place = cont_q;
  assign busy = (state_q != S_IDLE) | started_q;

endmodule : qrwb_top
`default_nettype wire

// ---- qrwb_properties.sv ----
// Port checks for the quad word read and wrap burst sequencer
`timescale 1ns/10ps
`default_nettype none
module qrwb_properties
  import qrwb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic quad_io_enable_bit,
  input wire logic quad_peripheral_mode,
  input wire logic soft_reset,
  input wire logic [qrwb_pkg::ADDR_W-1:0] mem_addr,
  input wire logic wrap_disable_bit,
  input wire logic [1:0] wrap_length_field,
  input wire logic execute_in_place,
  input wire logic busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_SOFT_RST: assert property (
    soft_reset |=> wrap_disable_bit && wrap_length_field == 2'h0
    && !execute_in_place) else $error("soft reset left wrap state");
  AST_OE_NIB: assert property (
    io_oe == 4'h0 || io_oe == 4'hF) else $error("partial enable");
  AST_CS_IDLE: assert property (
    cs_n_pin [*6] |-> io_oe == 4'h0) else $error("drive while idle");
  AST_QE_GATE: assert property (
    $rose(io_oe[0]) |-> quad_io_enable_bit || quad_peripheral_mode)
    else $error("read ran without quad enable");
  AST_WRAP_HOLD: assert property (
    $changed(wrap_disable_bit) |-> $past(soft_reset) || $past(busy))
    else $error("wrap setting changed outside a frame");
  AST_SECTION: assert property (
    io_oe == 4'hF && $past(io_oe) == 4'hF && $changed(mem_addr)
    && (!wrap_disable_bit || quad_peripheral_mode)
    |-> mem_addr[23:6] == $past(mem_addr[23:6]))
    else $error("wrapped address left its section");
  AST_FALL_LAUNCH: assert property (
    io_oe == 4'hF && $past(io_oe) == 4'hF && $changed(io_out)
    |-> !$past(sclk_pin, 3)) else $error("data moved off a fall");
  AST_XIP_ARM: assert property (
    $rose(execute_in_place) |-> !quad_peripheral_mode && $past(busy))
    else $error("continuous mode armed outside a read");
endmodule : qrwb_properties
bind qrwb_top qrwb_properties chk_u (.clk_sys, .rstn, .cs_n_pin,
  .sclk_pin, .io_out, .io_oe, .quad_io_enable_bit, .quad_peripheral_mode,
  .soft_reset, .mem_addr, .wrap_disable_bit, .wrap_length_field,
  .execute_in_place, .busy);
`default_nettype wire

// ---- qrwb_host_model.sv ----
// Host controller model driving chip select, serial clock and quad lines
`timescale 1ns/10ps
`default_nettype none
module qrwb_host_model
(
  input wire logic clk_sys,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic [3:0] io_in
);
  logic [3:0] drv_q = 4'h0;
  logic [3:0] hoe_q = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic [3:0] nib;
  logic [7:0] rd_q [0:79];
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
  end
  // Undriven lines show the inverse of their last level
  assign io_in = (hoe_q & drv_q) | (~hoe_q & io_oe & io_out)
    | (~hoe_q & ~io_oe & ~last_q);
  always @(posedge clk_sys) begin
    if ((hoe_q | io_oe) != 4'h0) last_q <= io_in;
  end
  task automatic tick(input logic [3:0] v, input logic [3:0] oe);
    drv_q <= v;
    hoe_q <= oe;
    repeat (4) @(posedge clk_sys);
    sclk_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    nib = io_in;
    sclk_pin <= 1'b0;
  endtask : tick
  // Last mode nibble: lines released before the launching fall
  task automatic tick_rel(input logic [3:0] v);
    drv_q <= v;
    hoe_q <= 4'hF;
    repeat (4) @(posedge clk_sys);
    sclk_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    hoe_q <= 4'h0;
    @(posedge clk_sys);
    nib = io_in;
    sclk_pin <= 1'b0;
  endtask : tick_rel
  task automatic start();
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : start
  task automatic stop();
    hoe_q <= 4'h0;
    cs_n_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : stop
  task automatic ser(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) tick({3'b111, v[i]}, 4'hF);
  endtask : ser
  task automatic quad(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) tick(v[4*i +: 4], 4'hF);
  endtask : quad
  task automatic rd(input int nd, input int nb);
    repeat (nd) tick(4'h0, 4'h0);
    for (int i = 0; i < nb; i++) begin
      tick(4'h0, 4'h0);
      rd_q[i][7:4] = nib;
      tick(4'h0, 4'h0);
      rd_q[i][3:0] = nib;
    end
  endtask : rd
endmodule : qrwb_host_model
`default_nettype wire

// ---- test_quad_word_read_wrap_burst.sv ----
// Testbench for the quad word read and wrap burst sequencer
`timescale 1ns/10ps
`default_nettype none
module test_quad_word_read_wrap_burst;
  import qrwb_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn, cs_n_pin, sclk_pin, soft_reset;
  logic quad_io_enable_bit, quad_peripheral_mode;
  logic [3:0] io_in, io_out, io_oe;
  logic [1:0] periph_dummy_code, periph_wrap_code, wrap_length_field;
  logic [23:0] mem_addr;
  logic [7:0] mem_rdata;
  logic wrap_disable_bit, execute_in_place, busy;
  int n_mismatch = 0;
  int num_checks = 0;
  int oe_cnt = 0;
  int c0;
  logic [7:0] wop [4] = '{OP_WORD_QUAD_READ, OP_OCTAL_WORD_READ,
    OP_QUAD_FAST_READ, OP_WORD_QUAD_READ};
  int wdm [4] = '{2, 0, 4, 2};
  logic [23:0] wad [4] = '{24'h2000FE, 24'h2000F0, 24'h2000FD, 24'h2000FE};
  qrwb_top dut_u (.clk_sys, .rstn, .cs_n_pin, .sclk_pin, .io_in, .io_out,
    .io_oe, .quad_io_enable_bit, .quad_peripheral_mode, .periph_dummy_code,
    .periph_wrap_code, .soft_reset, .mem_addr, .mem_rdata, .wrap_disable_bit,
    .wrap_length_field, .execute_in_place, .busy);
  qrwb_host_model host_u (.clk_sys, .io_out, .io_oe, .cs_n_pin, .sclk_pin,
    .io_in);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    mem_rdata <= mem_addr[7:0] ^ 8'hA5;
    oe_cnt <= oe_cnt + int'(io_oe != 4'h0);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_rd(input logic [23:0] a, input int wl, input int nb);
    logic [23:0] x, m;
    m = 24'(wl - 1);
    for (int i = 0; i < nb; i++) begin
      x = (wl == 0) ? a + 24'(i) : (a & ~m) | ((a + 24'(i)) & m);
      chk(host_u.rd_q[i], x[7:0] ^ 8'hA5);
    end
  endtask : chk_rd
  task automatic rdf(input logic [7:0] op, input logic [23:0] a,
    input logic [7:0] m, input int nd, input int nb);
    host_u.start();
    if (op != 8'h00) host_u.ser({24'h0, op}, 8);
    host_u.quad({8'h0, a}, 6);
    host_u.quad({28'h0, m[7:4]}, 1);
    host_u.tick_rel(m[3:0]);
    host_u.rd(nd, nb);
    host_u.stop();
  endtask : rdf
  task automatic setwrap(input logic [7:0] w);
    host_u.start();
    host_u.ser({24'h0, OP_SET_WRAP}, 8);
    host_u.ser({24'h0, w}, 32);
    host_u.stop();
  endtask : setwrap
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    soft_reset = 1'b0;
    quad_io_enable_bit = 1'b1;
    quad_peripheral_mode = 1'b0;
    periph_dummy_code = 2'h0;
    periph_wrap_code = 2'h0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(8'(wrap_disable_bit), 8'h01);
    rdf(OP_WORD_QUAD_READ, 24'h123456, 8'h00, 2, 4);
    chk_rd(24'h123456, 0, 4);
    chk(8'(busy), 8'h00);
    rdf(OP_OCTAL_WORD_READ, 24'h2340A0, 8'h1F, 0, 3);
    chk_rd(24'h2340A0, 0, 3);
    chk(8'(execute_in_place), 8'h00);
    quad_io_enable_bit <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      c0 = oe_cnt;
      rdf(wop[k], 24'h000010, 8'h20, 2, 2);
      chk(8'(oe_cnt - c0), 8'h00);
    end
    quad_io_enable_bit <= 1'b1;
    rdf(OP_WORD_QUAD_READ, 24'h004560, 8'h2F, 2, 2);
    chk(8'(execute_in_place), 8'h01);
    rdf(8'h00, 24'h007780, 8'h00, 2, 2);
    chk_rd(24'h007780, 0, 2);
    chk(8'(execute_in_place), 8'h00);
    rdf(OP_OCTAL_WORD_READ, 24'h004560, 8'h20, 0, 1);
    host_u.start();
    host_u.ser(32'hFF, 8);
    host_u.stop();
    chk(8'(execute_in_place), 8'h00);
    for (int k = 0; k < 4; k++) begin
      setwrap({1'b1, 2'(k), 1'b0, 4'hA});
      chk(8'(wrap_disable_bit), 8'h00);
      chk(8'(wrap_length_field), 8'(k));
      rdf(wop[k], wad[k], 8'h00, wdm[k], (8 << k) + 2);
      chk_rd(wad[k], 8 << k, (8 << k) + 2);
    end
    setwrap(8'h10);
    chk(8'(wrap_disable_bit), 8'h01);
    rdf(OP_WORD_QUAD_READ, 24'h2000FE, 8'h00, 2, 4);
    chk_rd(24'h2000FE, 0, 4);
    setwrap(8'h60);
    rdf(OP_WORD_QUAD_READ, 24'h000010, 8'h20, 2, 1);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(8'(wrap_disable_bit), 8'h01);
    chk(8'(wrap_length_field), 8'h00);
    chk(8'(execute_in_place), 8'h00);
    quad_peripheral_mode <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      periph_wrap_code <= 2'(k);
      periph_dummy_code <= 2'(3 - k);
      host_u.start();
      host_u.quad({24'h0, OP_BURST_WRAP_PM}, 2);
      host_u.quad(32'h3000FE, 6);
      host_u.rd(8 - 2 * k, (8 << k) + 2);
      host_u.stop();
      chk_rd(24'h3000FE, 8 << k, (8 << k) + 2);
    end
    chk(8'(wrap_disable_bit), 8'h01);
    give_verdict();
  end
endmodule : test_quad_word_read_wrap_burst
`default_nettype wire
